// >>> src/sic_pkg.sv
// Constants for the stack and interrupt control block
package sic_pkg;
    localparam int SP_W = 16;
    localparam int IO_AW = 6;
    localparam int PC_W = 14;
    localparam int NUM_IRQ = 25;
    localparam int VEC_W = 5;
    localparam logic [5:0] ADDR_SP_LOW = 6'h3D;
    localparam logic [5:0] ADDR_SP_HIGH = 6'h3E;
    localparam logic [15:0] LAST_SRAM_ADDR = 16'h08FF;
    localparam logic [15:0] PUSH_BYTE_STEP = 16'h0001;
    localparam logic [15:0] PUSH_ADDR_STEP = 16'h0002;
    localparam logic [13:0] VEC_BASE_LOW = 14'h0000;
    localparam logic [13:0] BOOT_BASE = 14'h3800;
    localparam logic [2:0] ENTRY_CYCLES = 3'h4;
    localparam logic [2:0] RETURN_FROM_INTERRUPT_CYCLES = 3'h4;
    localparam logic [4:0] RESET_VEC_NUM = 5'h00;
    typedef enum logic [1:0] {SIC_RUN, SIC_ENTRY, SIC_RETURN} sic_state_e;
endpackage

// >>> src/sic_core.sv
// Stack pointer and interrupt entry/return control
module sic_core (
    input wire logic mclk,
    input wire logic rst_b,
    // I/O register port
    input wire logic [sic_pkg::IO_AW-1:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Sequencer side
    input wire logic op_push,
    input wire logic op_pop,
    input wire logic op_call,
    input wire logic op_ret,
    input wire logic op_return_from_interrupt,
    input wire logic op_sei,
    input wire logic op_cli,
    input wire logic insn_boundary,
    input wire logic [sic_pkg::PC_W-1:0] pc,
    input wire logic vector_select,
    input wire logic boot_reset_fuse,
    input wire logic boot_lock_app_bit,
    input wire logic boot_lock_boot_bit,
    input wire logic [sic_pkg::PC_W-1:0] boot_start,
    // Peripheral side
    input wire logic [sic_pkg::NUM_IRQ-1:0] irq_event,
    input wire logic [sic_pkg::NUM_IRQ-1:0] irq_level,
    input wire logic [sic_pkg::NUM_IRQ-1:0] irq_is_level,
    input wire logic [sic_pkg::NUM_IRQ-1:0] irq_enable,
    input wire logic [sic_pkg::NUM_IRQ-1:0] flag_clear_wr,
    // Outputs
    output logic [sic_pkg::SP_W-1:0] stack_pointer,
    output logic global_enable,
    output logic [sic_pkg::NUM_IRQ-1:0] irq_flags,
    output logic irq_take,
    output logic irq_busy,
    output logic return_from_interrupt_busy,
    output logic [sic_pkg::PC_W-1:0] vector_addr,
    output logic [sic_pkg::PC_W-1:0] reset_vector
);
    logic [sic_pkg::SP_W-1:0] sp_r;
    logic gie_r;
    logic hold_r;
    logic [sic_pkg::NUM_IRQ-1:0] flag_r;
    logic [sic_pkg::NUM_IRQ-1:0] flag_nxt;
    logic [sic_pkg::NUM_IRQ-1:0] pending;
    logic [sic_pkg::VEC_W-1:0] win_num;
    logic win_any;
    logic lock_block;
    logic take;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [sic_pkg::PC_W-1:0] vec_r;
    sic_pkg::sic_state_e state_r;
    sic_pkg::sic_state_e state_nxt;
    logic [sic_pkg::SP_W-1:0] sp_nxt;
    logic gie_nxt;
    logic hold_nxt;
    logic ret_last;
    logic wr_high;
    logic wr_low;
    logic [sic_pkg::NUM_IRQ-1:0] flag_set;
    logic [sic_pkg::NUM_IRQ-1:0] flag_hw_clr;

    function automatic logic [sic_pkg::PC_W-1:0] vec_base(input logic sel,
            input logic [sic_pkg::PC_W-1:0] boot);
        vec_base = sel ? boot : sic_pkg::VEC_BASE_LOW;
    endfunction

    // Each vector occupies two words, so vector n sits at base + 2n
    function automatic logic [sic_pkg::PC_W-1:0] vec_addr(input logic [sic_pkg::PC_W-1:0] base,
            input logic [sic_pkg::VEC_W-1:0] num);
        vec_addr = base + {{(sic_pkg::PC_W-sic_pkg::VEC_W-1){1'b0}}, num, 1'b0};
    endfunction

    // Full six-bit compare; a partial decode would alias other I/O registers
    function automatic logic io_hit(input logic [sic_pkg::IO_AW-1:0] addr,
            input logic [sic_pkg::IO_AW-1:0] target);
        io_hit = (addr == target);
    endfunction

    function automatic logic in_boot(input logic [sic_pkg::PC_W-1:0] where,
            input logic [sic_pkg::PC_W-1:0] boot);
        in_boot = (where >= boot);
    endfunction

    // Stack moves down on stores and up on loads; wraps like any address adder
    function automatic logic [sic_pkg::SP_W-1:0] sp_move(input logic [sic_pkg::SP_W-1:0] sp,
            input logic [sic_pkg::SP_W-1:0] step, input logic down);
        sp_move = down ? sp - step : sp + step;
    endfunction

    // Scans from the top so the lowest numbered request is written last and wins
    function automatic logic [sic_pkg::VEC_W-1:0] lowest_pending(
            input logic [sic_pkg::NUM_IRQ-1:0] req);
        lowest_pending = '0;
        for (int i = sic_pkg::NUM_IRQ - 1; i >= 1; i--) begin
            if (req[i]) begin
                lowest_pending = sic_pkg::VEC_W'(i);
            end
        end
    endfunction

    // Level sources pass straight through; flag sources use the held flag
    assign pending = ((flag_r & ~irq_is_level) | (irq_level & irq_is_level)) & irq_enable;

    // Slot zero belongs to reset and is never taken here
    assign win_num = lowest_pending(pending);
    assign win_any = |pending[sic_pkg::NUM_IRQ-1:1];

    // Lock bits block interrupts while executing in the section they protect
    assign lock_block = (boot_lock_app_bit && !in_boot(pc, boot_start)) ||
                        (boot_lock_boot_bit && in_boot(pc, boot_start));

    // CLI in the same cycle vetoes; hold_r gives one instruction after SEI/RETURN_FROM_INTERRUPT
    assign take = (state_r == sic_pkg::SIC_RUN) && insn_boundary && gie_r && !op_cli &&
                  !hold_r && win_any && !lock_block;

    assign wr_high = io_wr && io_hit(io_addr, sic_pkg::ADDR_SP_HIGH);
    assign wr_low = io_wr && io_hit(io_addr, sic_pkg::ADDR_SP_LOW);

    // Entry outranks all: the sequencer is stalled while the core pushes
    always_comb begin
        sp_nxt = sp_r;
        if (take) begin
            sp_nxt = sp_move(sp_r, sic_pkg::PUSH_ADDR_STEP, 1'b1);
        end else if (wr_high) begin
            sp_nxt = {io_wdata, sp_r[7:0]};
        end else if (wr_low) begin
            sp_nxt = {sp_r[15:8], io_wdata};
        end else if (op_push) begin
            sp_nxt = sp_move(sp_r, sic_pkg::PUSH_BYTE_STEP, 1'b1);
        end else if (op_call) begin
            sp_nxt = sp_move(sp_r, sic_pkg::PUSH_ADDR_STEP, 1'b1);
        end else if (op_pop) begin
            sp_nxt = sp_move(sp_r, sic_pkg::PUSH_BYTE_STEP, 1'b0);
        end else if (op_ret || op_return_from_interrupt) begin
            sp_nxt = sp_move(sp_r, sic_pkg::PUSH_ADDR_STEP, 1'b0);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sp_r <= sic_pkg::LAST_SRAM_ADDR;
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // Only the enable bit is touched; other status bits are left to software
    always_comb begin
        gie_nxt = gie_r;
        if (take || op_cli) begin
            gie_nxt = 1'b0;
        end else if (op_sei || op_return_from_interrupt) begin
            gie_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gie_r <= 1'b0;
        end else begin
            gie_r <= gie_nxt;
        end
    end

    // Last return cycle; hold then spans the one main instruction that follows
    assign ret_last = (state_r == sic_pkg::SIC_RETURN) && (cnt_r == 3'h1);

    always_comb begin
        hold_nxt = hold_r;
        if (op_sei || ret_last) begin
            hold_nxt = 1'b1;
        end else if (insn_boundary) begin
            hold_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    // Set wins over both clears, so an event in the clearing cycle is kept
    assign flag_set = irq_event & ~irq_is_level;

    always_comb begin
        flag_hw_clr = '0;
        if (take) begin
            flag_hw_clr[win_num] = 1'b1;
        end
    end

    assign flag_nxt = (flag_r & ~flag_clear_wr & ~flag_hw_clr) | flag_set;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            sic_pkg::SIC_RUN: begin
                if (take) begin
                    state_nxt = sic_pkg::SIC_ENTRY;
                    cnt_nxt = sic_pkg::ENTRY_CYCLES - 3'h1;
                end else if (op_return_from_interrupt) begin
                    state_nxt = sic_pkg::SIC_RETURN;
                    cnt_nxt = sic_pkg::RETURN_FROM_INTERRUPT_CYCLES - 3'h1;
                end
            end
            sic_pkg::SIC_ENTRY, sic_pkg::SIC_RETURN: begin
                // Accepting cycle plus three busy cycles gives four in all
                if (cnt_r == 3'h1) begin
                    state_nxt = sic_pkg::SIC_RUN;
                end
                cnt_nxt = cnt_r - 3'h1;
            end
            default: begin
                state_nxt = sic_pkg::SIC_RUN;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= sic_pkg::SIC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Counter only matters in entry and return
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Base sampled at accept time; moving vectors during entry has no effect
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vec_r <= '0;
        end else if (take) begin
            vec_r <= vec_addr(vec_base(vector_select, boot_start), win_num);
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        io_rdata = 8'h00;
        if (io_hit(io_addr, sic_pkg::ADDR_SP_HIGH)) begin
            io_rdata = sp_r[15:8];
        end else if (io_hit(io_addr, sic_pkg::ADDR_SP_LOW)) begin
            io_rdata = sp_r[7:0];
        end
    end

    assign reset_vector = vec_addr(vec_base(boot_reset_fuse, boot_start),
                                   sic_pkg::RESET_VEC_NUM);
    assign stack_pointer = sp_r;
    assign global_enable = gie_r;
    assign irq_flags = flag_r;
    // Busy levels let the sequencer stall while the core owns the stack
    assign irq_take = take;
    assign irq_busy = (state_r == sic_pkg::SIC_ENTRY);
    assign return_from_interrupt_busy = (state_r == sic_pkg::SIC_RETURN);
    assign vector_addr = vec_r;
endmodule

// >>> verif/sic_core_asserts.sv
// Port-level checker for the stack and interrupt control core
module sic_core_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [sic_pkg::IO_AW-1:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic op_push,
    input wire logic op_pop,
    input wire logic op_call,
    input wire logic op_ret,
    input wire logic op_return_from_interrupt,
    input wire logic op_cli,
    input wire logic insn_boundary,
    input wire logic [sic_pkg::SP_W-1:0] stack_pointer,
    input wire logic global_enable,
    input wire logic irq_take,
    input wire logic irq_busy,
    input wire logic return_from_interrupt_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic q;
    // Entry and I/O writes outrank the stack ops
    assign q = !irq_take && !io_wr;
    property step(logic c, logic [15:0] k);
        c && q |=> stack_pointer == $past(stack_pointer) + k;
    endproperty
    AST_PUSH: assert property (step(op_push, 16'hFFFF))
        else $error("push step wrong");
    AST_POP: assert property (step(op_pop, 16'h0001))
        else $error("pop step wrong");
    AST_CALL: assert property (step(op_call, 16'hFFFE))
        else $error("call step wrong");
    AST_RET: assert property (step(op_ret, 16'h0002))
        else $error("return step wrong");
    AST_TAKE: assert property (irq_take |=> stack_pointer == $past(stack_pointer) - 16'h0002
        && !global_enable)
        else $error("entry pointer or enable wrong");
    AST_GATE: assert property (irq_take |-> global_enable && insn_boundary && !op_cli)
        else $error("take without enable or boundary");
    AST_BUSY: assert property (irq_take |=> irq_busy [*3] ##1 !irq_busy)
        else $error("entry length wrong");
    AST_RETURN_FROM_INTERRUPT: assert property (op_return_from_interrupt |=> return_from_interrupt_busy [*3] ##1 global_enable)
        else $error("return length or enable wrong");
    AST_CLI: assert property (op_cli |-> !irq_take ##1 !global_enable)
        else $error("disable not immediate");
    AST_WLOW: assert property (io_wr && !irq_take && io_addr == sic_pkg::ADDR_SP_LOW
        |=> stack_pointer[7:0] == $past(io_wdata))
        else $error("low byte write lost");
    AST_HOLD: assert property ($fell(return_from_interrupt_busy) |-> !irq_take)
        else $error("take right after return");
    cover property (irq_take);
    cover property (op_return_from_interrupt);
    cover property (io_wr && !irq_take);
endmodule

bind sic_core sic_core_chk u_chk (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .op_push(op_push), .op_pop(op_pop), .op_call(op_call),
    .op_ret(op_ret), .op_return_from_interrupt(op_return_from_interrupt), .op_cli(op_cli), .insn_boundary(insn_boundary),
    .stack_pointer(stack_pointer), .global_enable(global_enable), .irq_take(irq_take),
    .irq_busy(irq_busy), .return_from_interrupt_busy(return_from_interrupt_busy));

// >>> verif/sic_seq_model.sv
// Sequencer model: instruction boundaries and program counter
module sic_seq_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic irq_busy,
    input wire logic return_from_interrupt_busy,
    output logic insn_boundary,
    output logic [13:0] pc
);
    timeunit 1ns;
    timeprecision 1ns;
    // No instruction completes while entry or return owns the core
    always @(negedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            insn_boundary <= 1'b0;
            pc <= 14'h0000;
        end else begin
            insn_boundary <= !(irq_busy || return_from_interrupt_busy);
            pc <= pc + {13'h0000, insn_boundary};
        end
    end
endmodule

// >>> verif/stack_and_interrupt_control_bench.sv
// Self-checking bench for the stack and interrupt control core
module stack_and_interrupt_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_b = 0, io_wr = 0, vsel = 0, fuse = 0, gie, take, ibusy, rbusy, bnd;
    logic lock = 0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic [6:0] ops = 7'h00;
    logic [24:0] ev = 25'h0, en = 25'h0, clr = 25'h0, flags;
    logic [15:0] sp, sp0;
    logic [13:0] pc, vaddr, rvec;
    int err_count = 0, cmp_count = 0;
    always #4 mclk = ~mclk;
    sic_core u_dut (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .op_push(ops[0]), .op_pop(ops[1]),
        .op_call(ops[2]), .op_ret(ops[3]), .op_return_from_interrupt(ops[4]), .op_sei(ops[5]), .op_cli(ops[6]),
        .insn_boundary(bnd), .pc(pc), .vector_select(vsel), .boot_reset_fuse(fuse),
        .boot_lock_app_bit(lock), .boot_lock_boot_bit(1'b0), .boot_start(sic_pkg::BOOT_BASE),
        .irq_event(ev), .irq_level(25'h0), .irq_is_level(25'h0), .irq_enable(en),
        .flag_clear_wr(clr), .stack_pointer(sp), .global_enable(gie), .irq_flags(flags),
        .irq_take(take), .irq_busy(ibusy), .return_from_interrupt_busy(rbusy), .vector_addr(vaddr),
        .reset_vector(rvec));
    sic_seq_model u_seq (.mclk(mclk), .rst_b(rst_b), .irq_busy(ibusy), .return_from_interrupt_busy(rbusy),
        .insn_boundary(bnd), .pc(pc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input int i);
        ops[i] = 1'b1;
        @(negedge mclk);
        ops = 7'h00;
        @(negedge mclk);
    endtask
    task automatic pulse(input logic to_clr, input logic [24:0] m);
        if (to_clr) begin
            clr = m;
        end else begin
            ev = m;
        end
        @(negedge mclk);
        ev = 25'h0;
        clr = 25'h0;
        @(negedge mclk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge mclk);
        io_wr = 1'b0;
        @(negedge mclk);
    endtask
    task automatic wait_take;
        int n;
        n = 0;
        while (take !== 1'b1 && n < 30) begin
            @(negedge mclk);
            n++;
        end
        chk(take, 1'b1);
        @(negedge mclk);
    endtask
    task automatic t_reset;
        chk(sp, sic_pkg::LAST_SRAM_ADDR);
        io_addr = sic_pkg::ADDR_SP_HIGH;
        #1 chk(io_rdata, sic_pkg::LAST_SRAM_ADDR[15:8]);
        chk(rvec, sic_pkg::VEC_BASE_LOW);
        @(negedge mclk);
        fuse = 1'b1;
        #1 chk(rvec, sic_pkg::BOOT_BASE);
    endtask
    task automatic t_stack;
        wr(sic_pkg::ADDR_SP_HIGH, 8'h01);
        wr(sic_pkg::ADDR_SP_LOW, 8'h00);
        chk(sp, 16'h0100);
        op(0);
        chk(sp, 16'h00FF);
        op(2);
        chk(sp, 16'h00FD);
        op(1);
        chk(sp, 16'h00FE);
        op(3);
        chk(sp, 16'h0100);
    endtask
    task automatic t_irq;
        pulse(1'b0, 25'h80);
        chk(flags, 32'h80);
        pulse(1'b1, 25'h80);
        chk(flags, 32'h0);
        en = 25'h28;
        pulse(1'b0, 25'h28);
        chk(take, 1'b0);
        chk(flags, 32'h28);
        sp0 = sp;
        lock = 1'b1;
        op(5);
        // Counter sits in the application section, so the lock blocks entry
        chk(take, 1'b0);
        lock = 1'b0;
        #1;
        wait_take;
        chk(vaddr, sic_pkg::VEC_BASE_LOW + 14'h0006);
        chk(gie, 1'b0);
        chk(flags, 32'h20);
        chk(sp, sp0 - 16'h0002);
        // Entry holds busy for a fixed three cycles after the accepting cycle, four in all
        repeat (4) @(negedge mclk);
        vsel = 1'b1;
        op(4);
        wait_take;
        chk(vaddr, sic_pkg::BOOT_BASE + 14'h000A);
        chk(flags, 32'h0);
        chk(sp, sp0 - 16'h0002);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        t_reset;
        t_stack;
        t_irq;
        report_and_stop;
    end
    initial begin
        #20000;
        err_count++;
        report_and_stop;
    end
endmodule
